// File: src/video_capture_port.sv
`timescale 1ns/1ps
`default_nettype none
module video_capture_port
  import capture_pkg::*;
(
  input wire logic ref_clk_i, // System clock, 200 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] avs_address_i, // Register word index
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte enables
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Slave not ready
  input wire logic capture_clock, // Port clock from source
  input wire logic frame_start_n, // Frame start strobe, active low
  input wire logic line_end_n, // Line end strobe, active low
  input wire logic input_word_valid, // Data valid
  input wire logic field_parity, // Field parity
  input wire logic [15:0] capture_data, // Pixel word
  input wire logic refresh_req_i, // Screen refresh wants memory
  input wire logic other_req_i, // Other requesters want memory
  input wire logic mem_ack_i, // Granted access completes
  input wire logic [7:0] mem_rdata_i, // Mask byte read data
  output logic [2:0] arb_grant_o, // Grant: 0 refresh, 1 capture, 2 other
  output logic cap_we_o, // Capture access is a write
  output logic [23:0] cap_addr_o, // Capture access byte address
  output logic [15:0] cap_wdata_o // Capture write data
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [23:0] mbase;
    logic [23:0] cbase;
    logic [7:0] step;
    logic [7:0] scale;
    logic ovf;
    logic clk_d;
    logic [23:0] addr;
    logic [23:0] line_start;
    logic [2:0] line_cnt;
    logic [2:0] pix_cnt;
    logic [19:0] midx;
    drain_t st;
    logic [7:0] mbyte;
    logic [23:0] maddr;
    logic mvld;
    logic [2:0] gnt;
    logic cap_we;
    logic [23:0] cap_addr;
    logic [15:0] cap_wdata;
  } state_t;

  state_t r;
  state_t n;
  pins_t pins_raw;
  pins_t pins;
  cap_word_t push_w;
  cap_word_t fifo_w;
  cap_word_t drain_w;
  logic push;
  logic fifo_in_ready;
  logic fifo_vld;
  logic skid_ready;
  logic drain_vld;
  logic pop;
  logic rise;
  logic keep_line;
  logic keep_pix;
  logic mask_en;
  logic mask_hit;
  logic mask_bit;
  logic cap_ack;
  logic [23:0] mask_byte_addr;
  logic [7:0] rd_byte;

  // ****************************************************************
  // Pin synchronisers and buffers
  // ****************************************************************
  assign pins_raw = '{frame_n: frame_start_n, line_n: line_end_n, valid: input_word_valid,
                      field: field_parity, clk: capture_clock, data: capture_data};

  pin_sync #(.W($bits(pins_t))) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  word_fifo #(.W($bits(cap_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_w),
    .out_valid_o(fifo_vld),
    .out_ready_i(skid_ready),
    .out_data_o(fifo_w)
  );

  word_fifo #(.W($bits(cap_word_t)), .DEPTH(SKID_DEPTH)) u_skid (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_vld),
    .in_ready_o(skid_ready),
    .in_data_i(fifo_w),
    .out_valid_o(drain_vld),
    .out_ready_i(pop),
    .out_data_o(drain_w)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  assign rise = pins.clk && !r.clk_d;
  assign keep_line = keep_sample(r.line_cnt, r.scale[SC_VDEC_LSB +: 2], r.scale[SC_VODD_BIT] ^ pins.field);
  assign keep_pix = keep_sample(r.pix_cnt, r.scale[SC_HDEC_LSB +: 2], r.scale[SC_HODD_BIT]);
  assign mask_en = r.ctrl[CTRL_MASK_EN_BIT];
  assign mask_byte_addr = r.mbase + {7'h00, drain_w.midx[19:3]};
  assign mask_hit = r.mvld && (r.maddr == mask_byte_addr);
  assign mask_bit = r.mbyte[drain_w.midx[2:0]];
  assign cap_ack = mem_ack_i && r.gnt[1];

  always_comb begin
    n = r;
    push = 1'b0;
    pop = 1'b0;
    push_w = '{addr: r.addr, data: pins.data, midx: r.midx};
    rd_byte = 8'h00;
    case (avs_address_i)
      REG_CTRL_IDX: rd_byte = r.ctrl;
      REG_MBASE0_IDX: rd_byte = r.mbase[7:0];
      REG_MBASE1_IDX: rd_byte = r.mbase[15:8];
      REG_MBASE2_IDX: rd_byte = r.mbase[23:16];
      REG_CBASE0_IDX: rd_byte = r.cbase[7:0];
      REG_CBASE1_IDX: rd_byte = r.cbase[15:8];
      REG_CBASE2_IDX: rd_byte = r.cbase[23:16];
      REG_STEP_IDX: rd_byte = r.step;
      REG_SCALE_IDX: rd_byte = r.scale;
      REG_STATUS_IDX: begin
        rd_byte[ST_OVF_BIT] = r.ovf;
        rd_byte[ST_EMPTY_BIT] = !fifo_vld && !drain_vld;
        rd_byte[ST_FIELD_BIT] = pins.field;
      end
      default: rd_byte = 8'h00;
    endcase
    // Bus: one wait cycle, then answer
    n.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && r.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = avs_read_i ? {24'h000000, rd_byte} : 32'h00000000;
    end
    if (avs_write_i && !r.waitreq && avs_byteenable_i[0]) begin
      case (avs_address_i)
        REG_CTRL_IDX: n.ctrl = avs_writedata_i[7:0];
        REG_MBASE0_IDX: n.mbase[7:0] = avs_writedata_i[7:0];
        REG_MBASE1_IDX: n.mbase[15:8] = avs_writedata_i[7:0];
        REG_MBASE2_IDX: n.mbase[23:16] = avs_writedata_i[7:0];
        REG_CBASE0_IDX: n.cbase[7:0] = avs_writedata_i[7:0];
        REG_CBASE1_IDX: n.cbase[15:8] = avs_writedata_i[7:0];
        REG_CBASE2_IDX: n.cbase[23:16] = avs_writedata_i[7:0];
        REG_STEP_IDX: n.step = avs_writedata_i[7:0];
        REG_SCALE_IDX: n.scale = avs_writedata_i[7:0];
        REG_STATUS_IDX: n.ovf = r.ovf && !avs_writedata_i[ST_OVF_BIT];
        default: n.mvld = r.mvld;
      endcase
      n.mvld = 1'b0;
    end
    // Capture side: act once per port clock rising edge
    n.clk_d = pins.clk;
    if (rise && r.ctrl[CTRL_CAP_EN_BIT]) begin
      if (!pins.frame_n) begin
        n.addr = r.cbase;
        n.line_start = r.cbase;
        n.line_cnt = 3'h0;
        n.pix_cnt = 3'h0;
        n.midx = '0;
        n.mvld = 1'b0;
      end else if (!pins.line_n) begin
        n.line_cnt = r.line_cnt + 3'h1;
        n.pix_cnt = 3'h0;
        if (keep_line) begin
          n.line_start = r.line_start + {13'h0000, r.step, 3'h0};
          n.addr = r.line_start + {13'h0000, r.step, 3'h0};
        end else begin
          n.addr = r.line_start;
        end
      end else if (pins.valid) begin
        n.pix_cnt = r.pix_cnt + 3'h1;
        if (keep_line && keep_pix) begin
          push = 1'b1;
          n.addr = r.addr + WORD_BYTES;
          n.midx = r.midx + 20'h00001;
          if (!fifo_in_ready) begin
            n.ovf = 1'b1;
          end
        end
      end
    end
    // Drain: optional mask fetch, then frame buffer write
    case (r.st)
      D_IDLE: begin
        if (drain_vld) begin
          if (mask_en && !mask_hit) begin
            n.st = D_MASK;
            n.cap_we = 1'b0;
            n.cap_addr = mask_byte_addr;
          end else if (mask_en && !mask_bit) begin
            pop = 1'b1;
          end else begin
            n.st = D_WRITE;
            n.cap_we = 1'b1;
            n.cap_addr = drain_w.addr;
            n.cap_wdata = drain_w.data;
          end
        end
      end
      D_MASK: begin
        if (cap_ack) begin
          n.mbyte = mem_rdata_i;
          n.maddr = r.cap_addr;
          n.mvld = 1'b1;
          n.st = D_IDLE;
        end
      end
      D_WRITE: begin
        if (cap_ack) begin
          pop = 1'b1;
          n.st = D_IDLE;
          n.cap_we = 1'b0;
        end
      end
      default: n.st = D_IDLE;
    endcase
    // Arbiter: refresh, then capture, then others
    if (r.gnt == 3'b000) begin
      if (refresh_req_i) begin
        n.gnt = 3'b001;
      end else if (r.st != D_IDLE) begin
        n.gnt = 3'b010;
      end else if (other_req_i) begin
        n.gnt = 3'b100;
      end
    end else if (mem_ack_i) begin
      n.gnt = 3'b000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.waitreq <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign arb_grant_o = r.gnt;
  assign cap_we_o = r.cap_we;
  assign cap_addr_o = r.cap_addr;
  assign cap_wdata_o = r.cap_wdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic edge_ok;
  assign edge_ok = rise && r.ctrl[CTRL_CAP_EN_BIT];

  AST_EDGE_SAMPLE: assert property (push |-> rise && pins.valid && pins.frame_n && pins.line_n)
    else $error("word taken outside a valid port clock edge");
  AST_WRITE_WORD: assert property (r.st == D_WRITE |-> r.cap_we && !mask_en || r.cap_we)
    else $error("write state without write access");
  AST_VDROP: assert property (edge_ok && pins.frame_n && pins.line_n && pins.valid && !keep_line |-> !push)
    else $error("word stored on a dropped line");
  AST_HDROP: assert property (edge_ok && pins.frame_n && pins.line_n && pins.valid && !keep_pix
    |=> r.addr == $past(r.addr))
    else $error("dropped pixel moved the address");
  AST_FRAME_LOAD: assert property (edge_ok && !pins.frame_n |=> r.addr == $past(r.cbase) && r.midx == 20'h0)
    else $error("frame start did not load base");
  AST_LINE_STEP: assert property (edge_ok && pins.frame_n && !pins.line_n && keep_line
    |=> r.addr == $past(r.line_start) + {13'h0000, $past(r.step), 3'h0})
    else $error("line end did not apply step");
  AST_SKIP_NO_STEP: assert property (edge_ok && pins.frame_n && !pins.line_n && !keep_line
    |=> r.line_start == $past(r.line_start))
    else $error("dropped line applied step");
  AST_ADVANCE: assert property (push |=> r.addr == $past(r.addr) + WORD_BYTES)
    else $error("address not advanced by one word");
  AST_MASK_DROP: assert property (r.st == D_IDLE && drain_vld && mask_en && mask_hit && !mask_bit
    |-> pop ##1 r.st == D_IDLE)
    else $error("masked pixel not discarded");
  AST_MASK_FETCH: assert property (r.st == D_IDLE && drain_vld && mask_en && !mask_hit
    |=> r.st == D_MASK && r.cap_addr == $past(mask_byte_addr))
    else $error("mask byte not fetched");
  AST_ARB_PRIO: assert property (r.gnt == 3'b000 && refresh_req_i |=> r.gnt == 3'b001)
    else $error("refresh not granted first");
  AST_ARB_CAP: assert property (r.gnt == 3'b000 && !refresh_req_i && r.st != D_IDLE |=> r.gnt == 3'b010)
    else $error("capture not granted before others");
  AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && r.waitreq |=> !r.waitreq ##1 r.waitreq)
    else $error("bus answer not one cycle after request");
  AST_FIFO_OVF: assert property (push && !fifo_in_ready |=> r.ovf)
    else $error("overflow not flagged");

  COV_FRAME: cover property (edge_ok && !pins.frame_n ##[1:400] push);
  COV_WRITE: cover property (r.st == D_WRITE && cap_ack);
  COV_MASK_DROP: cover property (r.st == D_IDLE && drain_vld && mask_en && mask_hit && !mask_bit);
  COV_OVF: cover property (push && !fifo_in_ready);

endmodule : video_capture_port
`default_nettype wire

// File: src/capture_pkg.sv
// Overview of operation
// - Port takes 16-bit words on its own capture clock, up to 33 MHz.
// - Every accepted word that masking does not drop is written into the frame buffer memory.
// - Vertical reduction keeps one line in 2, 4 or 8; odd/even start selectable.
// - Horizontal reduction keeps one pixel in 2, 4 or 8; own odd/even choice bit, not affected by field parity.
// - Frame start pulse loads the capture base address into the address counter.
// - Line end pulse after a kept line adds the line step to line start; every line end reloads the counter.
// - Data sampled only while word valid is high; each word that reduction keeps, the FIFO has room for and masking does not drop starts a write.
// - Capture base address registers at 9C to 9E, software writable.
// - Line step register at 9F gives distance to next captured line.
// - With masking on, a pixel is written only if its mask bit is 1.
// - Mask bits fetched from base at 98-9A; enable bit in control 96.
// - Incoming words pass a 48-byte FIFO before memory writes.
// - Arbiter grants screen refresh first, capture second, others last.
package capture_pkg;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int MIDX_W = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int LINK_MAX_MHZ = 33;
  localparam int LINK_MIN_PERIOD_NS = 1000 / LINK_MAX_MHZ;
  localparam int LINK_MIN_SAMPLES = LINK_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FIFO_BYTES = 48;
  localparam int FIFO_DEPTH = FIFO_BYTES / (DATA_W / 8);
  localparam int SKID_DEPTH = 2;
  localparam logic [ADDR_W-1:0] WORD_BYTES = 24'h000002;
  localparam int STEP_SHIFT = 3;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_IDX = 8'h96;
  localparam logic [7:0] REG_MBASE0_IDX = 8'h98;
  localparam logic [7:0] REG_MBASE1_IDX = 8'h99;
  localparam logic [7:0] REG_MBASE2_IDX = 8'h9a;
  localparam logic [7:0] REG_CBASE0_IDX = 8'h9c;
  localparam logic [7:0] REG_CBASE1_IDX = 8'h9d;
  localparam logic [7:0] REG_CBASE2_IDX = 8'h9e;
  localparam logic [7:0] REG_STEP_IDX = 8'h9f;
  localparam logic [7:0] REG_SCALE_IDX = 8'ha0;
  localparam logic [7:0] REG_STATUS_IDX = 8'ha1;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_MASK_EN_BIT = 0;
  localparam int CTRL_CAP_EN_BIT = 1;
  localparam int SC_VDEC_LSB = 0;
  localparam int SC_VODD_BIT = 2;
  localparam int SC_HDEC_LSB = 4;
  localparam int SC_HODD_BIT = 6;
  localparam int ST_OVF_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FIELD_BIT = 2;
  localparam logic [7:0] REG_RST = 8'h00;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [MIDX_W-1:0] midx;
  } cap_word_t;

  typedef struct packed {
    logic frame_n;
    logic line_n;
    logic valid;
    logic field;
    logic clk;
    logic [DATA_W-1:0] data;
  } pins_t;

  typedef enum logic [1:0] {D_IDLE, D_MASK, D_WRITE} drain_t;

  // Keep one sample in 2**dec, phase shifted by odd
  function automatic logic keep_sample(input logic [2:0] cnt, input logic [1:0] dec, input logic odd);
    logic [2:0] msk;
    logic [2:0] ph;
    msk = 3'h0;
    case (dec)
      2'h1: msk = 3'h1;
      2'h2: msk = 3'h3;
      2'h3: msk = 3'h7;
      default: msk = 3'h0;
    endcase
    ph = cnt + {2'h0, odd};
    keep_sample = ((ph & msk) == 3'h0);
  endfunction : keep_sample

endpackage : capture_pkg

// File: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import capture_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [W-1:0] d_i, // Asynchronous inputs
  output logic [W-1:0] q_o // Synchronised inputs
);

  if (W < 1) begin : g_chk
    $error("pin_sync: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t r;
  sync_state_t n;

  always_comb begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_o = r.s2;

endmodule : pin_sync
`default_nettype wire

// File: src/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo
  import capture_pkg::*;
#(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic in_valid_i, // Word offered
  output logic in_ready_o, // Space available
  input wire logic [W-1:0] in_data_i, // Word in
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Consumer takes word
  output logic [W-1:0] out_data_o // Word out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("word_fifo: DEPTH must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t n;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : wrap_inc

  always_comb begin
    n = r;
    push = in_valid_i && (r.cnt != CW'(DEPTH));
    pop = out_ready_i && (r.cnt != '0);
    if (push) begin
      n.mem[r.wr] = in_data_i;
      n.wr = wrap_inc(r.wr);
    end
    if (pop) begin
      n.rd = wrap_inc(r.rd);
    end
    if (push && !pop) begin
      n.cnt = r.cnt + CW'(1);
    end else if (pop && !push) begin
      n.cnt = r.cnt - CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_ready_o = (r.cnt != CW'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rd];

endmodule : word_fifo
`default_nettype wire

// File: sim/video_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
  output logic capture_clock, // Port clock, still between beats
  output logic frame_start_n, // Frame start strobe
  output logic line_end_n, // Line end strobe
  output logic input_word_valid, // Word on data bus
  output logic field_parity, // Field parity
  output logic [15:0] capture_data // Pixel word
);
  initial begin
    capture_clock = 1'b0;
    frame_start_n = 1'b1;
    line_end_n = 1'b1;
    input_word_valid = 1'b0;
    field_parity = 1'b0;
    capture_data = 16'h0000;
  end

  // ****************************************************************
  // One port clock period; kind bit2 frame, bit1 line end, bit0 word
  // ****************************************************************
  task automatic beat(input logic [2:0] kind, input logic [15:0] d);
    // Change pins between system clock edges, once per time step
    #2.5;
    frame_start_n = !kind[2];
    line_end_n = !kind[1];
    input_word_valid = kind[0];
    capture_data = d;
    #80 capture_clock = 1'b1;
    #40;
    frame_start_n = 1'b1;
    line_end_n = 1'b1;
    input_word_valid = 1'b0;
    // Released bus shows the inverse so stale data never matches
    capture_data = ~d;
    #37.5 capture_clock = 1'b0;
  endtask : beat
endmodule : video_source_model
`default_nettype wire

// File: sim/video_capture_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module video_capture_port_tb_top;
  import capture_pkg::*;
  logic ref_clk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, refresh_req_i, other_req_i;
  logic mem_ack_i, hold_mem, cap_we_o, capture_clock, frame_start_n, line_end_n, input_word_valid, field_parity;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdw;
  logic [15:0] capture_data, cap_wdata_o;
  logic [2:0] arb_grant_o, mcnt;
  logic [23:0] cap_addr_o, mask_addr, la;
  logic [39:0] got_q[$];
  logic [39:0] exp_q[$];
  logic [2:0] gq[$];
  int num_errors, n_checks;

  video_capture_port video_capture_port_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h1), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .capture_clock(capture_clock), .frame_start_n(frame_start_n),
    .line_end_n(line_end_n), .input_word_valid(input_word_valid), .field_parity(field_parity),
    .capture_data(capture_data), .refresh_req_i(refresh_req_i), .other_req_i(other_req_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(8'h05), .arb_grant_o(arb_grant_o), .cap_we_o(cap_we_o),
    .cap_addr_o(cap_addr_o), .cap_wdata_o(cap_wdata_o));

  video_source_model video_source_model_i (.capture_clock(capture_clock), .frame_start_n(frame_start_n),
    .line_end_n(line_end_n), .input_word_valid(input_word_valid), .field_parity(field_parity),
    .capture_data(capture_data));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************************************
  // Memory model: acks every grant after three cycles unless held
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    mem_ack_i <= 1'b0;
    if (arb_grant_o != 3'h0 && !mem_ack_i && !hold_mem) begin
      mcnt <= mcnt + 3'h1;
      if (mcnt == 3'h2) begin
        mem_ack_i <= 1'b1;
        mcnt <= 3'h0;
        gq.push_back(arb_grant_o);
        if (arb_grant_o == 3'h2 && cap_we_o) got_q.push_back({cap_addr_o, cap_wdata_o});
        if (arb_grant_o == 3'h2 && !cap_we_o) mask_addr <= cap_addr_o;
      end
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) begin
      num_errors++;
      conclude();
    end
    rdw = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, rdw}, {32'h0, e});
  endtask : rdchk

  task automatic words(input int n, input int hk, input int ph, input logic keep, input logic [23:0] a);
    logic [15:0] d;
    for (int i = 0; i < n; i++) begin
      d = a[15:0] + 16'(i * 3);
      video_source_model_i.beat(3'h1, d);
      if (keep && (i + ph) % hk == 0) begin
        exp_q.push_back({a, d});
        a = a + 24'h000002;
      end
    end
  endtask : words

  task automatic drain(input logic exact);
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 3000) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
      conclude();
    end
    repeat (60) @(posedge ref_clk_i);
    if (exact) chk("write count", 40'(got_q.size()), 40'(exp_q.size()));
    foreach (exp_q[i]) chk("memory write", got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
  endtask : drain

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    refresh_req_i = 1'b0;
    other_req_i = 1'b0;
    hold_mem = 1'b0;
    mcnt = 3'h0;
    mask_addr = 24'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdchk("step reset", 8'h9f, 8'h00);
    bus(1'b1, 8'h9c, 8'h00);
    bus(1'b1, 8'h9d, 8'h10);
    bus(1'b1, 8'h9e, 8'h00);
    bus(1'b1, 8'h9f, 8'h04);
    bus(1'b1, 8'h10, 8'h5a);
    rdchk("base middle", 8'h9d, 8'h10);
    rdchk("line step", 8'h9f, 8'h04);
    rdchk("unmapped", 8'h10, 8'h00);
    bus(1'b1, 8'h96, 8'h02);
    video_source_model_i.beat(3'h4, 16'h0000);
    words(3, 1, 0, 1'b1, 24'h001000);
    video_source_model_i.beat(3'h2, 16'h0000);
    words(2, 1, 0, 1'b1, 24'h001020);
    drain(1'b1);
    for (int d = 1; d < 4; d++) begin
      bus(1'b1, 8'ha0, 8'(d << 4) | ((d == 2) ? 8'h40 : 8'h00));
      video_source_model_i.beat(3'h4, 16'h0000);
      words(9, 1 << d, (d == 2) ? 1 : 0, 1'b1, 24'h001000);
      drain(1'b1);
    end
    for (int d = 1; d < 4; d++) begin
      bus(1'b1, 8'ha0, 8'(d) | ((d == 2) ? 8'h04 : 8'h00));
      // Odd field on the last pass gives the odd phase without the odd bit
      video_source_model_i.field_parity = (d == 3);
      video_source_model_i.beat(3'h4, 16'h0000);
      la = 24'h001000;
      for (int l = 0; l < 9; l++) begin
        if (l > 0) video_source_model_i.beat(3'h2, 16'h0000);
        // Step applies only after a line that was kept
        if (l > 0 && (l - 1 + ((d >= 2) ? 1 : 0)) % (1 << d) == 0) la = la + 24'h000020;
        words(2, 1, 0, (l + ((d >= 2) ? 1 : 0)) % (1 << d) == 0, la);
      end
      drain(1'b1);
    end
    rdchk("field status", 8'ha1, 8'h06);
    video_source_model_i.field_parity = 1'b0;
    bus(1'b1, 8'ha0, 8'h00);
    bus(1'b1, 8'h98, 8'h00);
    bus(1'b1, 8'h99, 8'h20);
    bus(1'b1, 8'h9a, 8'h00);
    bus(1'b1, 8'h96, 8'h03);
    video_source_model_i.beat(3'h4, 16'h0000);
    for (int i = 0; i < 4; i++) video_source_model_i.beat(3'h1, 16'h7000 + 16'(i));
    exp_q.push_back({24'h001000, 16'h7000});
    exp_q.push_back({24'h001004, 16'h7002});
    drain(1'b1);
    chk("mask fetch address", {16'h0000, mask_addr}, {16'h0000, 24'h002000});
    bus(1'b1, 8'h96, 8'h02);
    gq.delete();
    hold_mem <= 1'b1;
    refresh_req_i <= 1'b1;
    other_req_i <= 1'b1;
    video_source_model_i.beat(3'h4, 16'h0000);
    words(1, 1, 0, 1'b1, 24'h001000);
    repeat (20) @(posedge ref_clk_i);
    refresh_req_i <= 1'b0;
    hold_mem <= 1'b0;
    for (int n = 0; n < 200 && gq.size() < 3; n++) @(posedge ref_clk_i);
    other_req_i <= 1'b0;
    chk("first grant", {37'h0, gq[0]}, 40'h1);
    chk("second grant", {37'h0, gq[1]}, 40'h2);
    chk("third grant", {37'h0, gq[2]}, 40'h4);
    drain(1'b1);
    hold_mem <= 1'b1;
    video_source_model_i.beat(3'h4, 16'h0000);
    words(30, 1, 0, 1'b0, 24'h001000);
    rdchk("overflow status", 8'ha1, 8'h01);
    hold_mem <= 1'b0;
    for (int i = 0; i < 24; i++) exp_q.push_back({24'h001000 + 24'(2 * i), 16'h1000 + 16'(i * 3)});
    drain(1'b0);
    bus(1'b1, 8'ha1, 8'h01);
    rdchk("status after clear", 8'ha1, 8'h02);
    conclude();
  end
endmodule : video_capture_port_tb_top
`default_nettype wire
